/* src/bus_release_arbiter.sv */
// Internal and external bus arbiters with external bus release.
// Assumes the request pin is asynchronous; all other inputs are on clk_sys.
//
// Strobed register access and the placing of the registers were left to the implementer.
`default_nettype none

module bus_release_arbiter
   import bus_release_pkg::*;
#(
   parameter int unsigned PCLK_DIV   = 4, // System to peripheral clock ratio n
   parameter int unsigned EXT_CYCLES = 3  // Length of one external bus cycle
)
(
   input  wire logic           clk_sys,                  // System clock
   input  wire logic           rst,                      // Asynchronous reset
   input  wire logic [3:0]     reg_addr,                 // Register address
   input  wire logic [7:0]     reg_wdata,                // Register write data
   input  wire logic           reg_wr,                   // Register write strobe
   input  wire logic           reg_rd,                   // Register read strobe
   output logic [7:0]          reg_rdata,                // Read data, cycle after strobe
   input  wire logic           ext_mode,                 // External extended mode
   input  wire logic           pin_input_control,        // Input control of request pin
   input  wire logic           ext_bus_request_n,        // Request pin, asynchronous
   output logic                ext_bus_grant_n,          // Grant pin, low when released
   output logic                ext_bus_drive_oe,         // Enable of address, data, strobes
   output logic                release_cancel_request_n, // Cancel request pin
   input  wire master_req_type cpu_req,                  // CPU request
   input  wire master_req_type xfer_req,                 // Transfer controller request
   input  wire logic           sleep_mode,               // CPU is asleep
   input  wire logic           standby_entry_req,        // Sleep into standby or clock stop
   input  wire logic           clock_write_req,          // Granted clock setting write
   input  wire logic [2:0]     clock_write_value,        // Value of that write
   output logic                cpu_grant,                // CPU owns internal bus
   output logic                transfer_controller_grant, // Transfer controller owns bus
   output logic                access_done,              // Owner's access finished
   output logic                standby_entry_ok,         // Sleep entry may proceed
   output logic [2:0]          clock_setting             // Applied clock setting
);
   localparam int PW = (PCLK_DIV > 1) ? $clog2(PCLK_DIV) : 1;
   localparam logic [PW-1:0] PHASE_LAST = PW'(PCLK_DIV - 1);

   typedef enum {OWN_NONE, OWN_CPU, OWN_XFER} owner_type;
   typedef enum {IS_IDLE, IS_SYNC, IS_RUN} int_state_type;
   typedef enum {REL_IDLE, REL_GRANTED, REL_RECOVER} rel_state_type;

   logic [7:0]     bus_control_one_q;
   logic [7:0]     bus_control_two_q;
   logic           req_sync1_q;
   logic           req_sync2_q;
   logic [PW-1:0]  phase_q;
   owner_type      owner_q;
   int_state_type  int_state_q;
   rel_state_type  rel_state_q;
   logic [7:0]     int_cnt_q;
   logic [7:0]     ext_cnt_q;
   logic [7:0]     per_cnt_q;
   logic           clk_pend_q;
   logic [2:0]     clk_val_q;
   logic           served_q;
   master_req_type sel_req;
   logic           release_en;
   logic           cancel_oe;
   logic           ext_wbuf;
   logic           per_wbuf;
   logic           cpu_alt;
   logic           rel_req;
   logic           is_ext;
   logic           is_pclk;
   logic           per_buffered;
   logic           ext_buffered;
   logic           resource_ok;
   logic           want_access;
   logic           switch_owner;
   owner_type      next_owner;
   logic           launch;
   logic           to_run;
   logic           ext_pending;
   logic [7:0]     run_cycles;

   // Total system clocks of one access of the given kind
   function automatic logic [7:0] access_cycles(input space_type sp, input logic wr);
      logic [7:0] c;
      c = RAM_CYCLES;
      unique case (sp)
         SPACE_RAM:        c = RAM_CYCLES;
         SPACE_SYS_REG:    c = wr ? SYS_WRITE_CYCLES : SYS_READ_CYCLES;
         SPACE_SLOW_REG:   c = 8'((wr ? SLOW_WRITE_PCLKS : SLOW_READ_PCLKS) * PCLK_DIV);
         SPACE_PERIPH_REG: c = 8'(PERIPH_PCLKS * PCLK_DIV);
         SPACE_EXTERNAL:   c = 8'(EXT_CYCLES);
         default:          c = RAM_CYCLES;
      endcase
      return c;
   endfunction

   // Control fields
   assign release_en = bus_control_one_q[BC1_RELEASE_EN_BIT];
   assign cancel_oe  = bus_control_one_q[BC1_CANCEL_OE_BIT];
   assign ext_wbuf   = bus_control_one_q[BC1_EXT_WBUF_BIT];
   assign per_wbuf   = bus_control_two_q[BC2_PERIPH_WBUF_BIT];
   assign cpu_alt    = bus_control_two_q[BC2_CPU_ALT_BIT];

   // Register writes
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         bus_control_one_q <= BUS_CONTROL_ONE_RESET;
         bus_control_two_q <= BUS_CONTROL_TWO_RESET;
      end
      else if (reg_wr)
      begin
         if (reg_addr == ADDR_BUS_CONTROL_ONE)
            bus_control_one_q <= reg_wdata;
         if (reg_addr == ADDR_BUS_CONTROL_TWO)
            bus_control_two_q <= reg_wdata;
      end
   end

   // Register reads; unmapped offsets and idle cycles read zero
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            ADDR_BUS_CONTROL_ONE: reg_rdata <= bus_control_one_q;
            ADDR_BUS_CONTROL_TWO: reg_rdata <= bus_control_two_q;
            ADDR_STATUS:          reg_rdata <= {1'b0, clk_pend_q, (per_cnt_q != 8'h00),
                                                (ext_cnt_q != 8'h00), (owner_q == OWN_XFER),
                                                (owner_q == OWN_CPU), (rel_state_q == REL_RECOVER),
                                                (rel_state_q == REL_GRANTED)};
            ADDR_CLOCK_SETTING:   reg_rdata <= {5'h00, clock_setting};
            default:              reg_rdata <= 8'h00;
         endcase
      end
      else
         reg_rdata <= 8'h00;
   end

   // Request pin crosses in through two flip-flops
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         req_sync1_q <= 1'b1;
         req_sync2_q <= 1'b1;
      end
      else
      begin
         req_sync1_q <= ext_bus_request_n;
         req_sync2_q <= req_sync1_q;
      end
   end

   // Free-running peripheral clock phase
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         phase_q <= '0;
      else if (phase_q == PHASE_LAST)
         phase_q <= '0;
      else
         phase_q <= phase_q + PW'(1);
   end

   // Decode of the current owner's request
   always_comb
   begin
      sel_req      = (owner_q == OWN_XFER) ? xfer_req : cpu_req;
      if (owner_q == OWN_NONE)
         sel_req.req = 1'b0;
      is_ext       = (sel_req.space == SPACE_EXTERNAL);
      is_pclk      = (sel_req.space == SPACE_SLOW_REG) || (sel_req.space == SPACE_PERIPH_REG);
      per_buffered = per_wbuf && sel_req.write && (sel_req.space == SPACE_PERIPH_REG);
      ext_buffered = ext_wbuf && sel_req.write && is_ext;
      run_cycles   = access_cycles(sel_req.space, sel_req.write);
   end

   // Release request qualified by mode and both enables
   assign rel_req = !req_sync2_q && ext_mode && release_en && pin_input_control;

   // An external access waits on a release and on a busy external cycle;
   // a slow or peripheral register access waits on a peripheral write still in the buffer
   always_comb
   begin
      if (is_ext)
         resource_ok = (ext_cnt_q == 8'h00) && (rel_state_q == REL_IDLE) && !rel_req;
      else if (is_pclk)
         resource_ok = (per_cnt_q == 8'h00);
      else
         resource_ok = 1'b1;
      want_access = sel_req.req && (int_state_q == IS_IDLE) && !access_done;
      ext_pending = want_access && is_ext && (rel_state_q != REL_IDLE);
   end

   // Owner hand-over, only between accesses
   always_comb
   begin
      next_owner = owner_q;
      unique case (owner_q)
         OWN_NONE:
         begin
            if (xfer_req.req)
               next_owner = OWN_XFER;
            else if (cpu_req.req)
               next_owner = OWN_CPU;
         end
         OWN_CPU:
         begin
            // Lowest priority; a locked sequence keeps the bus unless asleep.
            // Under alternation the CPU first finishes one access of its own.
            if (xfer_req.req && (!cpu_req.lock || sleep_mode) &&
                (served_q || !cpu_alt || !cpu_req.req || sleep_mode))
               next_owner = OWN_XFER;
            else if (!cpu_req.req)
               next_owner = OWN_NONE;
         end
         OWN_XFER:
         begin
            // Alternation waits for one access, else the CPU gets the bus only once the transfer controller drops its request
            if (!xfer_req.lock && cpu_req.req && ((cpu_alt && served_q) || !xfer_req.req))
               next_owner = OWN_CPU;
            else if (!xfer_req.req && !xfer_req.lock)
               next_owner = OWN_NONE;
         end
      endcase
      switch_owner = (next_owner != owner_q) && (int_state_q == IS_IDLE) && !access_done;
   end

   assign launch = want_access && resource_ok && !switch_owner;
   assign to_run = launch && (!is_pclk || phase_q == PHASE_LAST);

   // Owner register; acknowledge stays until the arbiter moves it
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         owner_q <= OWN_NONE;
      else if (switch_owner)
         owner_q <= next_owner;
   end

   // Owner has finished an access since its grant; paces alternation
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         served_q <= 1'b0;
      else if (switch_owner)
         served_q <= 1'b0;
      else if (access_done)
         served_q <= 1'b1;
   end

   // Internal access sequencer; buffered writes finish early for the master
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         int_state_q <= IS_IDLE;
         int_cnt_q   <= 8'h00;
         access_done <= 1'b0;
      end
      else
      begin
         access_done <= 1'b0;
         unique case (int_state_q)
            IS_IDLE:
            begin
               if (to_run)
               begin
                  int_state_q <= IS_RUN;
                  int_cnt_q   <= (ext_buffered || per_buffered) ? BUF_LEAD_CYCLES : run_cycles;
               end
               else if (launch)
                  int_state_q <= IS_SYNC;
            end
            IS_SYNC:
            begin
               // Waits out 1 to n-1 clocks for the next peripheral edge
               if (phase_q == PHASE_LAST)
               begin
                  int_state_q <= IS_RUN;
                  int_cnt_q   <= per_buffered ? BUF_LEAD_CYCLES : run_cycles;
               end
            end
            IS_RUN:
            begin
               if (int_cnt_q <= 8'h01)
               begin
                  int_state_q <= IS_IDLE;
                  access_done <= 1'b1;
               end
               else
                  int_cnt_q <= int_cnt_q - 8'h01;
            end
         endcase
      end
   end

   // External cycle engine runs on after a buffered write hands back
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         ext_cnt_q <= 8'h00;
      else if (to_run && is_ext)
         ext_cnt_q <= run_cycles;
      else if (ext_cnt_q != 8'h00)
         ext_cnt_q <= ext_cnt_q - 8'h01;
   end

   // Peripheral write buffer drains the rest of a buffered write
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         per_cnt_q <= 8'h00;
      else if (per_buffered && ((to_run) || (int_state_q == IS_SYNC && phase_q == PHASE_LAST)))
         per_cnt_q <= run_cycles;
      else if (per_cnt_q != 8'h00)
         per_cnt_q <= per_cnt_q - 8'h01;
   end

   // External arbiter: release wins, but only after the running cycle ends
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rel_state_q      <= REL_IDLE;
         ext_bus_grant_n  <= 1'b1;
         ext_bus_drive_oe <= 1'b1;
      end
      else
      begin
         unique case (rel_state_q)
            REL_IDLE:
            begin
               if (rel_req && ext_cnt_q == 8'h00)
               begin
                  rel_state_q      <= REL_GRANTED;
                  ext_bus_grant_n  <= 1'b0;
                  ext_bus_drive_oe <= 1'b0;
               end
            end
            REL_GRANTED:
            begin
               if (req_sync2_q)
               begin
                  rel_state_q     <= REL_RECOVER;
                  ext_bus_grant_n <= 1'b1;
               end
            end
            REL_RECOVER:
            begin
               // Drive resumes a cycle after grant rises to avoid a fight on the bus
               rel_state_q      <= REL_IDLE;
               ext_bus_drive_oe <= 1'b1;
            end
         endcase
      end
   end

   // Clock setting, held back while the bus is out
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         clock_setting <= CLOCK_SETTING_RESET;
         clk_pend_q    <= 1'b0;
         clk_val_q     <= CLOCK_SETTING_RESET;
      end
      else if (clock_write_req && rel_state_q != REL_IDLE)
      begin
         clk_pend_q <= 1'b1;
         clk_val_q  <= clock_write_value;
      end
      else if (clock_write_req)
      begin
         clock_setting <= clock_write_value;
         clk_pend_q    <= 1'b0;
      end
      else if (clk_pend_q && rel_state_q == REL_IDLE)
      begin
         clock_setting <= clk_val_q;
         clk_pend_q    <= 1'b0;
      end
   end

   // Cancel request, sleep gating and grant outputs
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         release_cancel_request_n  <= 1'b1;
         standby_entry_ok          <= 1'b0;
         cpu_grant                 <= 1'b0;
         transfer_controller_grant <= 1'b0;
      end
      else
      begin
         release_cancel_request_n  <= !(cancel_oe && rel_state_q == REL_GRANTED &&
                                        (ext_pending || standby_entry_req || clk_pend_q ||
                                         clock_write_req));
         standby_entry_ok          <= standby_entry_req && rel_state_q == REL_IDLE;
         cpu_grant                 <= switch_owner ? (next_owner == OWN_CPU) : (owner_q == OWN_CPU);
         transfer_controller_grant <= switch_owner ? (next_owner == OWN_XFER) : (owner_q == OWN_XFER);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_release_enables: assert property ($fell(ext_bus_grant_n) |-> $past(ext_mode && release_en && pin_input_control))
      else $error("bus released without mode and enables");
   a_release_tristate: assert property (!ext_bus_grant_n |-> !ext_bus_drive_oe)
      else $error("bus driven while granted away");
   a_ext_held_off: assert property ((rel_state_q != REL_IDLE) |-> !(launch && is_ext))
      else $error("external access started while released");
   a_clock_deferred: assert property ((rel_state_q == REL_GRANTED && clock_write_req) |=> $stable(clock_setting))
      else $error("clock setting applied while released");
   a_cancel_enable: assert property ($fell(release_cancel_request_n) |-> $past(cancel_oe))
      else $error("cancel request without its enable");
   a_release_wins: assert property ((rel_req && rel_state_q == REL_IDLE && ext_cnt_q == 8'h00) |=> !ext_bus_grant_n)
      else $error("release request lost to external access");
   a_ram_one_cycle: assert property ((to_run && sel_req.space == SPACE_RAM) |=> !access_done ##1 access_done)
      else $error("RAM access not one cycle");
   a_sys_write_three: assert property ((to_run && sel_req.space == SPACE_SYS_REG && sel_req.write)
                                       |=> !access_done ##1 !access_done ##1 !access_done ##1 access_done)
      else $error("system register write not three cycles");
   a_release_cycle_end: assert property ($fell(ext_bus_grant_n) |-> $past(ext_cnt_q == 8'h00))
      else $error("release during external cycle");
   a_recover_order: assert property ($rose(ext_bus_grant_n) |-> !ext_bus_drive_oe ##1 ext_bus_drive_oe)
      else $error("bus drive not restored after grant");
   a_cpu_lock_kept: assert property ((owner_q == OWN_CPU && cpu_req.req && cpu_req.lock && !sleep_mode)
                                     |=> owner_q == OWN_CPU)
      else $error("locked CPU lost the bus");
endmodule
`default_nettype wire

/* src/bus_release_pkg.sv */
// Constants and carriers shared by the bus release arbiter.
// Assumes a single 25 MHz system clock and a plain register port.
`default_nettype none
package bus_release_pkg;
   // Register port offsets
   localparam logic [3:0] ADDR_BUS_CONTROL_ONE = 4'h0;
   localparam logic [3:0] ADDR_BUS_CONTROL_TWO = 4'h4;
   localparam logic [3:0] ADDR_STATUS          = 4'h8;
   localparam logic [3:0] ADDR_CLOCK_SETTING   = 4'hC;
   // Field positions in bus_control_one
   localparam int BC1_RELEASE_EN_BIT = 0;
   localparam int BC1_CANCEL_OE_BIT  = 1;
   localparam int BC1_EXT_WBUF_BIT   = 2;
   // Field positions in bus_control_two
   localparam int BC2_PERIPH_WBUF_BIT = 0;
   localparam int BC2_CPU_ALT_BIT     = 1;
   // Reset values
   localparam logic [7:0] BUS_CONTROL_ONE_RESET = 8'h00;
   localparam logic [7:0] BUS_CONTROL_TWO_RESET = 8'h00;
   localparam logic [2:0] CLOCK_SETTING_RESET   = 3'h0;
   // Access lengths, system clocks for RAM and system registers
   localparam logic [7:0] RAM_CYCLES      = 8'h01;
   localparam logic [7:0] SYS_READ_CYCLES = 8'h02;
   localparam logic [7:0] SYS_WRITE_CYCLES = 8'h03;
   // Access lengths in peripheral clocks
   localparam logic [7:0] SLOW_READ_PCLKS  = 8'h02;
   localparam logic [7:0] SLOW_WRITE_PCLKS = 8'h03;
   localparam logic [7:0] PERIPH_PCLKS     = 8'h02;
   // Cycles a buffered write holds the bus before others run alongside
   localparam logic [7:0] BUF_LEAD_CYCLES = 8'h02;

   typedef enum logic [2:0] {
      SPACE_RAM,
      SPACE_SYS_REG,
      SPACE_SLOW_REG,
      SPACE_PERIPH_REG,
      SPACE_EXTERNAL
   } space_type;

   // One internal master's request
   typedef struct packed {
      logic      req;
      logic      write;
      logic      lock;
      space_type space;
   } master_req_type;
endpackage
`default_nettype wire

/* tb/ext_master_model.sv */
// External bus master that asks for the external bus.
// Assumes the bench raises want_bus and reads the grant pin.
`default_nettype none
module ext_master_model
(
   input  wire logic clk_sys,          // System clock
   input  wire logic rst,              // Reset
   input  wire logic want_bus,         // Bench wants the bus
   output logic      ext_bus_request_n // Request pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Held low until the bench lets go; going high ends the release
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
         ext_bus_request_n <= 1'b1;
      else
         ext_bus_request_n <= ~want_bus;
endmodule
`default_nettype wire

/* tb/tb.sv */
// Bench for the bus release arbiter.
// Assumes the master model drives the request pin.
`default_nettype none
module tb
   import bus_release_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, rst, reg_wr, reg_rd, ext_mode, pin_ic, want_bus, stby, clk_wr, sleep;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rd;
   logic [2:0] clk_val, clock_setting;
   master_req_type cpu_req, xfer_req;
   wire logic req_n, grant_n, oe, cancel_n, cpu_g, xfer_g, done, stby_ok;
   int failures, check_count, cycles, n;

   bus_release_arbiter #(.PCLK_DIV(2), .EXT_CYCLES(2)) dut (.clk_sys(clk_sys), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ext_mode(ext_mode), .pin_input_control(pin_ic),
      .ext_bus_request_n(req_n), .ext_bus_grant_n(grant_n), .ext_bus_drive_oe(oe),
      .release_cancel_request_n(cancel_n), .cpu_req(cpu_req), .xfer_req(xfer_req),
      .sleep_mode(sleep), .standby_entry_req(stby), .clock_write_req(clk_wr),
      .clock_write_value(clk_val), .cpu_grant(cpu_g), .transfer_controller_grant(xfer_g),
      .access_done(done), .standby_entry_ok(stby_ok), .clock_setting(clock_setting));
   ext_master_model peer (.clk_sys(clk_sys), .rst(rst), .want_bus(want_bus), .ext_bus_request_n(req_n));

   // 25 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic wrap_up();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Cut a hang short; the whole run needs far fewer cycles
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         wrap_up();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Sampling at the edge sees the values of the cycle before it
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      rd = reg_rdata;
   endtask

   task automatic wait_done(input int max);
      n = 0;
      do
      begin
         tick(1);
         n++;
      end
      while (done !== 1'b1 && n < max);
   endtask

   // Spacing of back-to-back accesses by one owner
   task automatic t_gap(input space_type s, input logic w, input int lo, input int hi);
      cpu_req <= '{1'b1, w, 1'b0, s};
      wait_done(60);
      wait_done(60);
      check(8'(n >= lo && n <= hi), 8'h01);
      cpu_req <= '0;
      tick(12);
   endtask

   task automatic t_regs();
      reg_read(ADDR_BUS_CONTROL_TWO);
      check(rd, BUS_CONTROL_TWO_RESET);
      reg_write(4'h2, 8'hFF);
      reg_read(4'h2); // Unmapped place reads zero
      check(rd, 8'h00);
      check(8'(clock_setting), 8'(CLOCK_SETTING_RESET));
   endtask

   // Locked CPU keeps the bus, sleep hands it over, alternation interleaves
   task automatic t_owner();
      cpu_req <= '{1'b1, 1'b0, 1'b1, SPACE_RAM};
      wait_done(20);
      xfer_req <= '{1'b1, 1'b0, 1'b0, SPACE_RAM};
      wait_done(20);
      wait_done(20);
      check(8'({cpu_g, xfer_g}), 8'h02);
      sleep <= 1'b1;
      wait_done(20);
      wait_done(20);
      check(8'({cpu_g, xfer_g}), 8'h01);
      sleep <= 1'b0;
      cpu_req <= '{1'b1, 1'b0, 1'b0, SPACE_RAM};
      reg_write(ADDR_BUS_CONTROL_TWO, 8'h02);
      wait_done(20);
      wait_done(20);
      check(8'({cpu_g, xfer_g}), 8'h02);
      wait_done(20);
      check(8'({cpu_g, xfer_g}), 8'h01);
      cpu_req <= '0;
      xfer_req <= '0;
      tick(12);
   endtask

   task automatic t_release();
      want_bus <= 1'b1;
      tick(12);
      check(8'(grant_n), 8'h01);
      want_bus <= 1'b0;
      tick(4); // Old low request must leave the synchroniser before enabling
      reg_write(ADDR_BUS_CONTROL_ONE, 8'h03);
      want_bus <= 1'b1;
      do tick(1); while (req_n !== 1'b0);
      n = 0;
      do begin tick(1); n++; end while (grant_n !== 1'b0 && n < 20);
      check(8'(n), 8'h03);
      check(8'(oe), 8'h00);
      xfer_req <= '{1'b1, 1'b0, 1'b0, SPACE_RAM};
      wait_done(20);
      check(8'(n < 20), 8'h01);
      xfer_req <= '0;
      tick(6);
      cpu_req <= '{1'b1, 1'b0, 1'b0, SPACE_EXTERNAL};
      clk_wr <= 1'b1;
      clk_val <= 3'h5;
      stby <= 1'b1;
      tick(1);
      clk_wr <= 1'b0;
      wait_done(20);
      check(8'(n), 8'h14);
      check(8'(cancel_n), 8'h00);
      check(8'(clock_setting), 8'h00);
      check(8'(stby_ok), 8'h00);
      reg_read(ADDR_STATUS);
      check(rd & 8'h01, 8'h01);
      want_bus <= 1'b0;
      do tick(1); while (req_n !== 1'b1);
      n = 0;
      do begin tick(1); n++; end while (grant_n !== 1'b1 && n < 20);
      check(8'(n), 8'h03);
      check(8'(oe), 8'h00);
      tick(1);
      check(8'(oe), 8'h01);
      wait_done(20);
      check(8'(n < 20), 8'h01);
      cpu_req <= '0;
      tick(8);
      check(8'(clock_setting), 8'h05);
      check(8'(stby_ok), 8'h01);
      stby <= 1'b0;
   endtask

   // Reset, then the scenarios in turn
   initial
   begin
      {rst, reg_wr, reg_rd, want_bus, stby, clk_wr} = 6'h20;
      {ext_mode, pin_ic} = 2'h3;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      clk_val = 3'h0;
      cpu_req = '0;
      xfer_req = '0;
      sleep = 1'b0;
      tick(12);
      rst <= 1'b0;
      t_regs();
      t_gap(SPACE_RAM, 1'b0, 3, 3);
      t_gap(SPACE_SYS_REG, 1'b0, 4, 4);
      t_gap(SPACE_SYS_REG, 1'b1, 5, 5);
      t_gap(SPACE_SLOW_REG, 1'b0, 6, 7);
      t_gap(SPACE_SLOW_REG, 1'b1, 8, 9);
      t_gap(SPACE_PERIPH_REG, 1'b1, 6, 7);
      t_owner();
      t_release();
      wrap_up();
   end
endmodule
`default_nettype wire
